// File: mdod_pkg.sv
// Purpose: shared constants and carriers of the modular object dictionary
// Assumes: four-slot station, eight 16-bit channels per slot at most
// Notes:   abort codes follow the usual service data abort values
package mdod_pkg;

   localparam int unsigned NUM_SLOTS     = 4;
   localparam int unsigned CH_PER_SLOT   = 8;
   localparam int unsigned WORDS_PER_SEG = 4;
   localparam int unsigned FIFO_DEPTH    = 16;

   localparam logic [7:0]  SLOT_COUNT    = 8'(NUM_SLOTS);
   localparam logic [3:0]  SEG_BYTES     = 4'h8;

   // index areas, module n owns base + 16 * n .. base + 16 * n + 15
   localparam logic [3:0]  AREA_IN       = 4'h6;
   localparam logic [3:0]  AREA_OUT      = 4'h7;
   localparam logic [3:0]  AREA_INFO     = 4'h9;
   localparam logic [3:0]  ENTRY_BASE    = 4'h0;
   localparam logic [7:0]  RXMAP_HI      = 8'h16;
   localparam logic [7:0]  TXMAP_HI      = 8'h1a;
   localparam logic [15:0] IDX_MODNO     = 16'h217f;
   localparam logic [7:0]  SUB_MODNO     = 8'h01;
   localparam logic [15:0] IDX_CHMASK    = 16'h2180;
   localparam logic [7:0]  SUB_CHMASK    = 8'h03;
   localparam logic [15:0] IDX_DEVINFO   = 16'hf000;
   localparam logic [7:0]  SUB_DEVINFO   = 8'h01;
   localparam logic [15:0] IDX_EXPCFG    = 16'hf030;
   localparam logic [7:0]  SUB_FIRST     = 8'h01;
   localparam logic [7:0]  SUB_LAST_CH   = 8'h08;
   localparam logic [7:0]  SUB_LAST_CFG  = 8'h04;
   localparam logic [7:0]  SUB_MAPCNT    = 8'h00;

   // setting ranges
   localparam logic [15:0] MAP_MAX       = 16'h0008;
   localparam logic [15:0] MODNO_MAX     = 16'h0003;
   localparam logic [15:0] BYTE_MAX      = 16'h00ff;
   localparam logic [15:0] WORD_MAX      = 16'hffff;

   // values after reset
   localparam logic [3:0]  MAP_RST       = 4'h0;
   localparam logic [1:0]  MODNO_RST     = 2'h0;
   localparam logic [7:0]  CHMASK_RST    = 8'h00;
   localparam logic [7:0]  CFG_RST       = 8'h00;
   localparam logic [15:0] WORD_RST      = 16'h0000;
   localparam logic [15:0] FWCNT_RST     = 16'h0000;

   localparam logic [31:0] ABORT_NONE    = 32'h00000000;
   localparam logic [31:0] ABORT_WO_RD   = 32'h06010001;
   localparam logic [31:0] ABORT_RO_WR   = 32'h06010002;
   localparam logic [31:0] ABORT_NOEXIST = 32'h06020000;
   localparam logic [31:0] ABORT_RANGE   = 32'h06090030;
   localparam logic [31:0] ABORT_STATE   = 32'h08000022;

   typedef enum logic [1:0] {AL_INIT, AL_PREOP, AL_SAFEOP, AL_OP} mdod_al_e;
   typedef enum logic {TX_IDLE, TX_RUN} mdod_tx_e;

   typedef struct packed {
      logic        wr;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [15:0] data;
   } mdod_sdo_req_s;

   typedef struct packed {
      logic        abort;
      logic [31:0] code;
      logic [15:0] data;
   } mdod_sdo_rsp_s;

   typedef struct packed {
      logic [15:0] index;
      logic        part;
      logic [3:0]  len;
      logic [63:0] data;
   } mdod_pdo_seg_s;

endpackage

// File: mdod_top.sv
// Purpose: object dictionary, pdo segmenting and firmware intake of a modular slave
// Assumes: state, scan, input image and pdo ports come from logic on mclk
// Notes:   one sdo in flight; answer held until taken
// Operation
// R1 - cyclic data only in op, tx also safe-op
// R2 - sdo requests accepted any time after init
// R3 - master maps pdos before cyclic exchange
// R4 - expected config: master in pre-op or auto-built
// R5 - input area objects feed tx pdos
// R6 - output area objects fed by rx pdos
// R7 - information area shows scanned module types
// R8 - device area holds station-wide parameters
// R9 - module n owns sixteen indices per area
// R10 - addressing covers module numbers up to 255
// R11 - pdo segments carry at most eight bytes
// R12 - inputs leave in tx pdos, outputs from rx
// R13 - index is sixteen bits
// R14 - subindex is eight bits
// R15 - each object is read-only, write-only or read-write
// R16 - range bounds readback or setting values
// R17 - object usable only in its listed states
// R18 - accept firmware update bytes via file access
// R19 - slots numbered zero to three left to right
// R20 - bad access or state answered with abort
// R21 - out-of-range write aborted, value kept
`timescale 1ns/1ps

module mdod_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = count_q != (AW+1)'(DEPTH);
   assign out_valid = count_q != '0;
   assign out_data  = mem_q[rd_ptr_q];

   always_ff @(posedge mclk) begin
      if (push) mem_q[wr_ptr_q] <= in_data;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
         count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

module mdod_top (
   input  wire logic                                  mclk,
   input  wire logic                                  reset_n,
   input  mdod_pkg::mdod_al_e                         al_state,
   input  wire logic                                  cycle_tick,
   input  wire logic [mdod_pkg::NUM_SLOTS-1:0][7:0]   slot_type,
   input  wire logic [mdod_pkg::NUM_SLOTS-1:0][mdod_pkg::CH_PER_SLOT-1:0][15:0] in_word,
   output logic      [mdod_pkg::NUM_SLOTS-1:0][mdod_pkg::CH_PER_SLOT-1:0][15:0] out_word,
   input  wire logic                                  sdo_req_valid,
   input  mdod_pkg::mdod_sdo_req_s                    sdo_req,
   output logic                                       sdo_req_ready,
   output logic                                       sdo_rsp_valid,
   output mdod_pkg::mdod_sdo_rsp_s                    sdo_rsp,
   input  wire logic                                  sdo_rsp_ready,
   output logic                                       tx_valid,
   output mdod_pkg::mdod_pdo_seg_s                    tx_seg,
   input  wire logic                                  tx_ready,
   input  wire logic                                  rx_valid,
   input  mdod_pkg::mdod_pdo_seg_s                    rx_seg,
   output logic                                       rx_ready,
   input  wire logic                                  fw_valid,
   input  wire logic [7:0]                            fw_byte,
   output logic                                       fw_wr,
   output logic      [7:0]                            fw_data,
   output logic      [15:0]                           fw_count
);
   localparam int unsigned NS = mdod_pkg::NUM_SLOTS;
   localparam int unsigned NC = mdod_pkg::CH_PER_SLOT;

   // dictionary storage
   logic [NS-1:0][NC-1:0][15:0] out_word_q;
   logic [NS-1:0][3:0]          rxcnt_q;
   logic [NS-1:0][3:0]          txcnt_q;
   logic [NS-1:0][7:0]          chmask_q;
   logic [NS-1:0][7:0]          exp_cfg_q;
   logic [1:0]                  mod_sel_q;
   logic                        build_done_q;
   logic                        req_ready_q;
   logic                        rsp_valid_q;
   mdod_pkg::mdod_sdo_rsp_s     rsp_q;
   logic                        rx_ready_q;
   logic                        fw_wr_q;
   logic [7:0]                  fw_data_q;
   logic [15:0]                 fw_count_q;

   // sdo decode; the 8-bit module field lets any n up to 255 decode, absent ones abort
   wire [15:0] idx      = sdo_req.index; // R13
   wire [7:0]  sub      = sdo_req.sub; // R14
   wire        wr       = sdo_req.wr;
   wire        take     = sdo_req_valid & req_ready_q;
   wire [7:0]  area_mod = idx[11:4]; // R10
   wire        mod_ok   = area_mod < mdod_pkg::SLOT_COUNT; // R19
   wire        map_ok   = idx[7:0] < mdod_pkg::SLOT_COUNT; // R10
   wire        sub_ch   = sub >= mdod_pkg::SUB_FIRST && sub <= mdod_pkg::SUB_LAST_CH;
   wire        blk0     = idx[3:0] == mdod_pkg::ENTRY_BASE; // R9
   wire        o_in     = idx[15:12] == mdod_pkg::AREA_IN && blk0 && mod_ok && sub_ch; // R5
   wire        o_out    = idx[15:12] == mdod_pkg::AREA_OUT && blk0 && mod_ok && sub_ch; // R6
   wire        o_info   = idx[15:12] == mdod_pkg::AREA_INFO && blk0 && mod_ok
                          && sub == mdod_pkg::SUB_FIRST; // R7
   wire        o_rxm    = idx[15:8] == mdod_pkg::RXMAP_HI && map_ok
                          && sub == mdod_pkg::SUB_MAPCNT;
   wire        o_txm    = idx[15:8] == mdod_pkg::TXMAP_HI && map_ok
                          && sub == mdod_pkg::SUB_MAPCNT;
   wire        o_modno  = idx == mdod_pkg::IDX_MODNO && sub == mdod_pkg::SUB_MODNO;
   wire        o_mask   = idx == mdod_pkg::IDX_CHMASK && sub == mdod_pkg::SUB_CHMASK;
   wire        o_dev    = idx == mdod_pkg::IDX_DEVINFO && sub == mdod_pkg::SUB_DEVINFO; // R8
   wire        o_cfg    = idx == mdod_pkg::IDX_EXPCFG && sub >= mdod_pkg::SUB_FIRST
                          && sub <= mdod_pkg::SUB_LAST_CFG; // R8
   wire        hit      = o_in | o_out | o_info | o_rxm | o_txm | o_modno | o_mask
                          | o_dev | o_cfg;
   wire [1:0]  a_slot   = idx[5:4];
   wire [1:0]  m_slot   = idx[1:0];
   wire [2:0]  ch       = 3'(sub - mdod_pkg::SUB_FIRST);
   wire [1:0]  c_slot   = 2'(sub - mdod_pkg::SUB_FIRST);

   // access attributes and states
   wire        is_ro    = o_in | o_info | o_dev; // R15
   wire        is_wo    = o_out; // R15
   wire        st_pre   = al_state == mdod_pkg::AL_PREOP;
   wire        st_op    = al_state == mdod_pkg::AL_OP;
   wire        cfg_obj  = o_rxm | o_txm | o_cfg;
   wire        st_ok    = (o_in | o_out) ? st_op :
                          o_mask ? st_pre :
                          cfg_obj ? (wr ? st_pre : (st_pre | st_op)) :
                          (st_pre | st_op); // R17 R3 R4
   wire [15:0] rng_max  = (o_rxm | o_txm) ? mdod_pkg::MAP_MAX :
                          o_modno ? mdod_pkg::MODNO_MAX :
                          (o_mask | o_cfg) ? mdod_pkg::BYTE_MAX : mdod_pkg::WORD_MAX; // R16
   wire        in_rng   = sdo_req.data <= rng_max;
   wire [31:0] ab_code  = !hit ? mdod_pkg::ABORT_NOEXIST :
                          !st_ok ? mdod_pkg::ABORT_STATE :
                          (wr & is_ro) ? mdod_pkg::ABORT_RO_WR :
                          (!wr & is_wo) ? mdod_pkg::ABORT_WO_RD :
                          (wr & !in_rng) ? mdod_pkg::ABORT_RANGE :
                          mdod_pkg::ABORT_NONE; // R20 R21
   wire        commit   = take & wr & (ab_code == mdod_pkg::ABORT_NONE);
   wire [15:0] rd_val   = o_in ? in_word[a_slot][ch] :
                          o_info ? {8'h00, slot_type[a_slot]} :
                          o_rxm ? {12'h000, rxcnt_q[m_slot]} :
                          o_txm ? {12'h000, txcnt_q[m_slot]} :
                          o_modno ? {14'h0000, mod_sel_q} :
                          o_mask ? {8'h00, chmask_q[mod_sel_q]} :
                          o_dev ? {8'h00, mdod_pkg::SLOT_COUNT} :
                          o_cfg ? {8'h00, exp_cfg_q[c_slot]} : 16'h0000;

   // sdo handshake: ready only outside init and with no answer pending
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
      end else if (take) begin
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b1;
         // a refused read must not leak the value of an object it may not reach
         rsp_q       <= '{abort: ab_code != mdod_pkg::ABORT_NONE, code: ab_code,
                          data: (wr || ab_code != mdod_pkg::ABORT_NONE) ? 16'h0000 : rd_val}; // R20 R17
      end else if (!rsp_valid_q || sdo_rsp_ready) begin
         rsp_valid_q <= 1'b0;
         req_ready_q <= al_state != mdod_pkg::AL_INIT; // R2
      end
   end

   // rx pdo decode
   wire       rx_take = rx_valid & rx_ready_q & st_op
                        & rx_seg.index[15:8] == mdod_pkg::RXMAP_HI
                        & rx_seg.index[7:0] < mdod_pkg::SLOT_COUNT; // R1 R6
   wire [1:0] rx_slot = rx_seg.index[1:0];

   // dictionary writes; an rx pdo wins over an sdo write to the same word
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_word_q   <= '0;
         rxcnt_q      <= {NS{mdod_pkg::MAP_RST}};
         txcnt_q      <= {NS{mdod_pkg::MAP_RST}};
         chmask_q     <= {NS{mdod_pkg::CHMASK_RST}};
         exp_cfg_q    <= {NS{mdod_pkg::CFG_RST}};
         mod_sel_q    <= mdod_pkg::MODNO_RST;
         build_done_q <= 1'b0;
      end else begin
         if (!build_done_q) begin
            exp_cfg_q    <= slot_type; // R4
            build_done_q <= 1'b1;
         end
         if (commit && o_out) out_word_q[a_slot][ch] <= sdo_req.data;
         if (commit && o_rxm) rxcnt_q[m_slot] <= sdo_req.data[3:0]; // R3
         if (commit && o_txm) txcnt_q[m_slot] <= sdo_req.data[3:0]; // R3
         if (commit && o_modno) mod_sel_q <= sdo_req.data[1:0]; // R21
         if (commit && o_mask) chmask_q[mod_sel_q] <= sdo_req.data[7:0];
         if (commit && o_cfg && build_done_q) exp_cfg_q[c_slot] <= sdo_req.data[7:0]; // R4
         for (int k = 0; k < mdod_pkg::WORDS_PER_SEG; k++) begin
            if (rx_take && {1'b0, rx_seg.part, 2'(k)} < rxcnt_q[rx_slot]) begin
               out_word_q[rx_slot][{rx_seg.part, 2'(k)}] <= rx_seg.data[k*16 +: 16]; // R12
            end
         end
      end
   end

   // tx segmenter: walks slots 0..3, two 8-byte parts each, skips unmapped
   mdod_pkg::mdod_tx_e tx_st_q;
   logic [1:0]         tx_slot_q;
   logic               tx_part_q;
   logic               tx_valid_q;
   mdod_pkg::mdod_pdo_seg_s tx_seg_q;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   mdod_pkg::mdod_pdo_seg_s fifo_out;
   logic [63:0]        seg_data;

   wire       tx_st_ok = al_state == mdod_pkg::AL_SAFEOP || st_op; // R1
   wire [3:0] part_base = {1'b0, tx_part_q, 2'b00};
   wire [3:0] tx_rem   = txcnt_q[tx_slot_q] - part_base;
   wire       tx_need  = txcnt_q[tx_slot_q] > part_base;
   wire [3:0] tx_len   = (tx_rem >= 4'(mdod_pkg::WORDS_PER_SEG)) ? mdod_pkg::SEG_BYTES
                                                                 : {tx_rem[2:0], 1'b0}; // R11
   wire       tx_run   = tx_st_q == mdod_pkg::TX_RUN && tx_st_ok;
   wire       tx_push  = tx_run & tx_need & fifo_in_ready; // R5 R12
   wire       tx_step  = tx_run & (!tx_need | fifo_in_ready);
   wire       tx_last  = tx_slot_q == 2'(NS - 1) && tx_part_q;
   wire       fifo_pop = !tx_valid_q || tx_ready;
   wire mdod_pkg::mdod_pdo_seg_s push_seg = '{index: {mdod_pkg::TXMAP_HI, 6'h00, tx_slot_q},
                                             part: tx_part_q, len: tx_len, data: seg_data};

   for (genvar k = 0; k < mdod_pkg::WORDS_PER_SEG; k++) begin : g_word
      wire [2:0] tch = {tx_part_q, 2'(k)};
      assign seg_data[k*16 +: 16] = ({1'b0, tch} < txcnt_q[tx_slot_q]) ?
                                    in_word[tx_slot_q][tch] : 16'h0000;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_st_q   <= mdod_pkg::TX_IDLE;
         tx_slot_q <= 2'h0;
         tx_part_q <= 1'b0;
      end else begin
         case (tx_st_q)
            mdod_pkg::TX_IDLE: begin
               if (cycle_tick && tx_st_ok) begin
                  tx_st_q   <= mdod_pkg::TX_RUN;
                  tx_slot_q <= 2'h0;
                  tx_part_q <= 1'b0;
               end
            end
            mdod_pkg::TX_RUN: begin
               if (!tx_st_ok || (tx_step && tx_last)) begin
                  tx_st_q <= mdod_pkg::TX_IDLE; // R1
               end else if (tx_step) begin
                  tx_part_q <= !tx_part_q;
                  if (tx_part_q) tx_slot_q <= tx_slot_q + 2'h1;
               end
            end
            default: tx_st_q <= mdod_pkg::TX_IDLE;
         endcase
      end
   end

   // segments queue up so a stalled link backs up into the segmenter
   mdod_fifo #(
      .WIDTH ($bits(mdod_pkg::mdod_pdo_seg_s)),
      .DEPTH (mdod_pkg::FIFO_DEPTH)
   ) u_txq (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (tx_push),
      .in_data   (push_seg),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out)
   );

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_valid_q <= 1'b0;
         tx_seg_q   <= '0;
      end else if (fifo_pop) begin
         tx_valid_q <= fifo_out_valid;
         tx_seg_q   <= fifo_out;
      end
   end

   // rx is always drained; frames outside op are dropped, not stalled
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_ready_q <= 1'b0;
         fw_wr_q    <= 1'b0;
         fw_data_q  <= 8'h00;
         fw_count_q <= mdod_pkg::FWCNT_RST;
      end else begin
         rx_ready_q <= 1'b1;
         fw_wr_q    <= fw_valid && st_pre; // R18
         if (fw_valid && st_pre) begin
            fw_data_q  <= fw_byte;
            fw_count_q <= fw_count_q + 16'h0001;
         end
      end
   end

   assign out_word      = out_word_q;
   assign sdo_req_ready = req_ready_q;
   assign sdo_rsp_valid = rsp_valid_q;
   assign sdo_rsp       = rsp_q;
   assign tx_valid      = tx_valid_q;
   assign tx_seg        = tx_seg_q;
   assign rx_ready      = rx_ready_q;
   assign fw_wr         = fw_wr_q;
   assign fw_data       = fw_data_q;
   assign fw_count      = fw_count_q;

   sequence s_take;
      sdo_req_valid && req_ready_q;
   endsequence

   sequence s_held;
      rsp_valid_q && !req_ready_q;
   endsequence

   AST_TX_GATED: assert property (@(posedge mclk) disable iff (!reset_n) // R1
      tx_push |-> (al_state == mdod_pkg::AL_OP || al_state == mdod_pkg::AL_SAFEOP))
      else $error("tx segment queued outside op or safe-op");
   AST_RX_GATED: assert property (@(posedge mclk) disable iff (!reset_n) // R1
      (!st_op && !commit) |=> $stable(out_word_q))
      else $error("output image changed outside op");
   AST_SDO_ANSWER: assert property (@(posedge mclk) disable iff (!reset_n) // R2
      s_take |=> s_held)
      else $error("sdo request not answered next cycle");
   AST_READY_BACK: assert property (@(posedge mclk) disable iff (!reset_n) // R2
      (rsp_valid_q && sdo_rsp_ready && !take && al_state != mdod_pkg::AL_INIT) |=> req_ready_q)
      else $error("sdo ready not restored after answer");
   AST_RO_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // R20
      (take && wr && o_in && st_op) |=> (rsp_q.abort && rsp_q.code == mdod_pkg::ABORT_RO_WR))
      else $error("write to read-only object not aborted");
   AST_RANGE_KEEP: assert property (@(posedge mclk) disable iff (!reset_n) // R21
      (take && wr && o_modno && st_ok && sdo_req.data > mdod_pkg::MODNO_MAX)
      |=> (rsp_q.code == mdod_pkg::ABORT_RANGE && $stable(mod_sel_q)))
      else $error("out of range module number accepted");
   AST_STATE_ABORT: assert property (@(posedge mclk) disable iff (!reset_n) // R17
      (take && o_mask && st_op) |=> rsp_q.code == mdod_pkg::ABORT_STATE)
      else $error("channel mask reached outside pre-op");
   AST_NO_MODULE: assert property (@(posedge mclk) disable iff (!reset_n) // R10
      (take && idx[15:12] == mdod_pkg::AREA_IN && area_mod >= mdod_pkg::SLOT_COUNT)
      |=> rsp_q.code == mdod_pkg::ABORT_NOEXIST)
      else $error("absent module object not aborted");
   AST_SEG_LEN: assert property (@(posedge mclk) disable iff (!reset_n) // R11
      tx_valid_q |-> (tx_seg_q.len != 4'h0 && tx_seg_q.len <= mdod_pkg::SEG_BYTES))
      else $error("pdo segment length out of bounds");
   AST_MAP_PREOP: assert property (@(posedge mclk) disable iff (!reset_n) // R3
      $changed(txcnt_q) |-> $past(al_state) == mdod_pkg::AL_PREOP)
      else $error("tx mapping changed outside pre-op");
   AST_AUTOBUILD: assert property (@(posedge mclk) disable iff (!reset_n) // R4
      $rose(build_done_q) |-> exp_cfg_q == $past(slot_type))
      else $error("expected config not built from scan");
endmodule

// File: mdod_master_model.sv
// Purpose: fieldbus master side of the tx pdo stream
// Assumes: tx_ready changes only on the falling edge of mclk
// Notes:   slow mode stalls every other cycle to hold segments
`timescale 1ns/1ps
module mdod_master_model (
   input  wire logic              mclk,
   input  wire logic              slow,
   input  wire logic              tx_valid,
   input  mdod_pkg::mdod_pdo_seg_s tx_seg,
   output logic                   tx_ready,
   output int                     n_seg,
   output mdod_pkg::mdod_pdo_seg_s first_seg
);
   initial begin
      tx_ready = 1'b0;
      n_seg = 0;
      first_seg = '0;
   end
   always @(negedge mclk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   // a segment counts only at the edge that takes it
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) begin
         if (n_seg == 0) first_seg <= tx_seg;
         n_seg <= n_seg + 1;
      end
   end
endmodule

// File: mdod_top_bench.sv
// Purpose: self-checking bench of the modular object dictionary
// Assumes: design samples on rising mclk, bench drives on falling
// Notes:   sdo answers are checked from a queue by a watcher
`timescale 1ns/1ps
module mdod_top_bench;
   logic                    mclk = 1'b0;
   logic                    reset_n = 1'b0;
   mdod_pkg::mdod_al_e      al_state = mdod_pkg::AL_PREOP;
   logic                    cycle_tick = 1'b0;
   logic                    sdo_req_valid = 1'b0;
   logic                    rx_valid = 1'b0;
   logic                    fw_valid = 1'b0;
   logic [7:0]              fw_byte = 8'h00;
   logic [3:0][7:0]         slot_type;
   logic [3:0][7:0][15:0]   in_word, out_word;
   mdod_pkg::mdod_sdo_req_s sdo_req = '0;
   mdod_pkg::mdod_sdo_rsp_s sdo_rsp;
   mdod_pkg::mdod_pdo_seg_s tx_seg, first_seg;
   mdod_pkg::mdod_pdo_seg_s rx_seg = '0;
   logic                    sdo_req_ready, sdo_rsp_valid, tx_valid, tx_ready, rx_ready, fw_wr;
   logic [7:0]              fw_data;
   logic [15:0]             fw_count;
   int                      n_seg, n_mismatch = 0, num_checks = 0;
   logic [31:0]             rng = 32'had8800b6;
   mdod_pkg::mdod_sdo_rsp_s expq[$];

   always #2 mclk = ~mclk;

   mdod_top i_mdod_top (.mclk, .reset_n, .al_state, .cycle_tick, .slot_type, .in_word,
      .out_word, .sdo_req_valid, .sdo_req, .sdo_req_ready, .sdo_rsp_valid, .sdo_rsp,
      .sdo_rsp_ready(1'b1), .tx_valid, .tx_seg, .tx_ready, .rx_valid, .rx_seg, .rx_ready,
      .fw_valid, .fw_byte, .fw_wr, .fw_data, .fw_count);
   mdod_master_model i_mdod_master_model (.mclk, .slow(1'b1), .tx_valid, .tx_seg, .tx_ready,
      .n_seg, .first_seg);

   function automatic logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one request in flight; the answer is noted before the request goes out
   task automatic sdo(logic wr, logic [15:0] ix, logic [7:0] sb, logic [15:0] d,
                      logic [31:0] c, logic [15:0] r);
      int i;
      expq.push_back('{c != 32'h0, c, r});
      sdo_req = '{wr, ix, sb, d};
      sdo_req_valid = 1'b1;
      for (i = 0; i < 50 && sdo_req_ready !== 1'b1; i++) @(negedge mclk);
      if (i == 50) begin
         n_mismatch++;
         give_verdict();
      end
      @(negedge mclk);
      sdo_req_valid = 1'b0;
      @(negedge mclk);
   endtask

   always @(negedge mclk) begin
      if (reset_n && sdo_rsp_valid === 1'b1) begin
         if (expq.size() == 0) chk("sdo_extra", 1, 0);
         else chk("sdo_rsp", sdo_rsp, expq.pop_front());
      end
   end

   initial begin
      logic [63:0] d;
      int k;
      for (k = 0; k < 32; k++) in_word[k/8][k%8] = 16'(nxt());
      slot_type = nxt();
      repeat (8) @(negedge mclk);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      sdo(0, 16'hf000, 8'h01, 0, 32'h0, 16'h0004);
      sdo(0, 16'h9030, 8'h01, 0, 32'h0, 16'(slot_type[3]));
      sdo(0, 16'hf030, 8'h02, 0, 32'h0, 16'(slot_type[1]));
      sdo(0, 16'h6040, 8'h01, 0, mdod_pkg::ABORT_NOEXIST, 0);
      sdo(1, 16'h217f, 8'h01, 4, mdod_pkg::ABORT_RANGE, 0);
      sdo(1, 16'h217f, 8'h01, 3, 32'h0, 0);
      sdo(0, 16'h217f, 8'h01, 0, 32'h0, 16'h0003);
      sdo(1, 16'h2180, 8'h03, 16'h00a5, 32'h0, 0);
      sdo(0, 16'h2180, 8'h03, 0, 32'h0, 16'h00a5);
      sdo(1, 16'hf000, 8'h01, 1, mdod_pkg::ABORT_RO_WR, 0);
      sdo(0, 16'h6000, 8'h01, 0, mdod_pkg::ABORT_STATE, 0);
      sdo(1, 16'h1601, 8'h00, 4, 32'h0, 0);
      sdo(1, 16'h1a00, 8'h00, 5, 32'h0, 0);
      sdo(1, 16'h1a00, 8'h00, 9, mdod_pkg::ABORT_RANGE, 0);
      d = nxt();
      fw_byte = d[7:0];
      fw_valid = 1'b1;
      @(negedge mclk);
      fw_valid = 1'b0;
      chk("fw_wr", fw_wr, 1);
      chk("fw_data", fw_data, d[7:0]);
      chk("fw_count", fw_count, 1);
      cycle_tick = 1'b1;
      @(negedge mclk);
      cycle_tick = 1'b0;
      repeat (10) @(negedge mclk);
      chk("tx_preop", n_seg, 0);
      al_state = mdod_pkg::AL_OP;
      @(negedge mclk);
      sdo(0, 16'h6000, 8'h01, 0, 32'h0, in_word[0][0]);
      sdo(0, 16'h7000, 8'h01, 0, mdod_pkg::ABORT_WO_RD, 0);
      sdo(1, 16'h1a00, 8'h00, 1, mdod_pkg::ABORT_STATE, 0);
      sdo(0, 16'h1a00, 8'h00, 0, 32'h0, 16'h0005);
      sdo(1, 16'h6000, 8'h01, 1, mdod_pkg::ABORT_RO_WR, 0);
      sdo(0, 16'h2180, 8'h03, 0, mdod_pkg::ABORT_STATE, 0);
      sdo(1, 16'h7010, 8'h05, 16'h1234, 32'h0, 0);
      d = {nxt(), nxt()};
      rx_seg = '{16'h1601, 1'b0, 4'h8, d};
      rx_valid = 1'b1;
      @(negedge mclk);
      rx_valid = 1'b0;
      for (k = 0; k < 4; k++) chk("out_word", out_word[1][k], d[k*16+:16]);
      chk("out_word_sdo", out_word[1][4], 16'h1234);
      chk("rx_ready", rx_ready, 1);
      cycle_tick = 1'b1;
      @(negedge mclk);
      cycle_tick = 1'b0;
      for (k = 0; k < 60 && n_seg < 2; k++) @(negedge mclk);
      repeat (10) @(negedge mclk);
      chk("tx_count", n_seg, 2);
      chk("tx_first", first_seg, {16'h1a00, 1'b0, 4'h8, in_word[0][3:0]});
      al_state = mdod_pkg::AL_SAFEOP;
      sdo(0, 16'hf000, 8'h01, 0, mdod_pkg::ABORT_STATE, 0);
      rx_seg.data = ~d;
      rx_valid = 1'b1;
      @(negedge mclk);
      rx_valid = 1'b0;
      chk("rx_safeop", out_word[1][0], d[15:0]);
      cycle_tick = 1'b1;
      @(negedge mclk);
      cycle_tick = 1'b0;
      for (k = 0; k < 60 && n_seg < 4; k++) @(negedge mclk);
      chk("tx_safeop", n_seg, 4);
      al_state = mdod_pkg::AL_INIT;
      repeat (3) @(negedge mclk);
      chk("init_ready", sdo_req_ready, 0);
      chk("sdo_left", expq.size(), 0);
      give_verdict();
   end
endmodule
